// ==== hw/scr_regs.sv ====
// System control register bank driving side-band signals to neighbours.
// Assumes a single-cycle register port driven from the system clock domain,
// and that all side-band inputs come from logic on the same clock.
module scr_regs
  import scr_pkg::*;
(
  // Clock and resets
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic COLD_RESET_N,
  // Register slave port
  input wire logic BUS_SEL,
  input wire logic BUS_WRITE,
  input wire logic [7:0] BUS_ADDR,
  input wire logic [31:0] BUS_WDATA,
  output logic [31:0] BUS_RDATA,
  output logic BUS_READY,
  // Master-port attributes
  output logic [PROT_W-1:0] USB0_MASTER_PROT,
  output logic [USER_W-1:0] USB0_MASTER_USER_SIDEBAND,
  output logic [PROT_W-1:0] USB1_MASTER_PROT,
  output logic [USER_W-1:0] USB1_MASTER_USER_SIDEBAND,
  output logic [PROT_W-1:0] CARD_MASTER_PROT,
  output logic [USER_W-1:0] CARD_MASTER_USER_SIDEBAND,
  // Card clock phase selects
  output logic [PHASE_W-1:0] CARD_DRV_PHASE,
  output logic [PHASE_W-1:0] CARD_SMPL_PHASE,
  // Watchdog pause
  input wire logic [WD_N-1:0] CPU_DEBUG,
  output logic [WD_N-1:0] WD_PAUSE,
  // Boot controls
  output logic BOOT_WARM_PINMUX,
  output logic BOOT_WARM_IO,
  output logic BOOTROM_WAIT_STATE,
  output logic BOOT_MEM_REMAP,
  // Fabric interface enables
  output logic [FABRIC_N-1:0] FABRIC_EN,
  // ECC and parity
  input wire logic [ECC_N-1:0] ECC_IRQ_SRC,
  output logic ECC_IRQ,
  output logic [PARITY_N-1:0] PARITY_IRQ,
  input wire logic L2_WRITE,
  output logic L2_CORRUPT_SINGLE,
  output logic L2_CORRUPT_DOUBLE
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ATTR_W-1:0] usb0_attr;
    logic [ATTR_W-1:0] usb1_attr;
    logic [ATTR_W-1:0] card_attr;
    logic [PHASE_W-1:0] drv_sel;
    logic [PHASE_W-1:0] smpl_sel;
    logic [WD_N-1:0] wd_dbg;
    logic warm_pinmux;
    logic warm_io;
    logic wait_state;
    logic safe_update;
    logic [IMAGE_W-1:0] last_image;
    logic [31:0] sw_state;
    logic warm_en;
    logic [31:0] warm_start;
    logic [31:0] warm_len;
    logic [31:0] warm_exec;
    logic [31:0] warm_crc;
    logic remap;
    logic global_disable;
    logic [FABRIC_N-1:0] indiv_en;
    logic [ECC_N-1:0] ecc_mask;
    logic [1:0] l2_inj;
    logic [PARITY_N-1:0] parity_inj;
    logic [HANDOFF_N-1:0][31:0] handoff;
    logic [31:0] rdata;
    logic ready;
    logic [FABRIC_N-1:0] fabric_en;
    logic ecc_irq;
    logic [PARITY_N-1:0] parity_irq;
  } scr_state_t;

  scr_state_t cur;
  scr_state_t next_cur;
  logic warm_rst_n;
  logic wr;
  logic rd;

  assign warm_rst_n = RESET_N & COLD_RESET_N;
  assign wr = BUS_SEL & BUS_WRITE;
  assign rd = BUS_SEL & ~BUS_WRITE;

  // ----------------------------------------------------------------
  // Register access and side-band logic
  // ----------------------------------------------------------------
  always_comb begin
    next_cur = cur;
    next_cur.ready = BUS_SEL;
    next_cur.rdata = WORD_RST;
    // Writes to unmapped offsets are dropped and reads return zero.
    if (wr) begin
      if (BUS_ADDR[7:5] == HANDOFF_PAGE) begin
        next_cur.handoff[BUS_ADDR[4:2]] = BUS_WDATA;
      end else begin
        case ({BUS_ADDR[7:2], 2'b00})
          OFS_USB_MASTER_ATTR_REG0: begin
            next_cur.usb0_attr = BUS_WDATA[ATTR_W-1:0];
          end
          OFS_USB_MASTER_ATTR_REG1: begin
            next_cur.usb1_attr = BUS_WDATA[ATTR_W-1:0];
          end
          OFS_CARD_MASTER_ATTR_REG: begin
            next_cur.card_attr = BUS_WDATA[ATTR_W-1:0];
          end
          OFS_CARD_CLK_PHASE: begin
            next_cur.drv_sel = BUS_WDATA[PHASE_W-1:0];
            next_cur.smpl_sel = BUS_WDATA[SMPL_POS +: PHASE_W];
          end
          OFS_WD_DEBUG: begin
            next_cur.wd_dbg = BUS_WDATA[WD_N-1:0];
          end
          OFS_BOOT_CTRL: begin
            next_cur.warm_pinmux = BUS_WDATA[BOOT_PINMUX_POS];
            next_cur.warm_io = BUS_WDATA[BOOT_IO_POS];
            next_cur.wait_state = BUS_WDATA[BOOT_WAIT_POS];
            next_cur.safe_update = BUS_WDATA[BOOT_SAFE_POS];
          end
          OFS_LAST_IMAGE: begin
            next_cur.last_image = BUS_WDATA[IMAGE_W-1:0];
          end
          OFS_BOOT_CODE_SCRATCH_STATE: begin
            next_cur.sw_state = BUS_WDATA;
          end
          OFS_WARM_ENABLE: begin
            next_cur.warm_en = BUS_WDATA[0];
          end
          OFS_WARM_START: begin
            // The low two bits are stored as written; software keeps them zero.
            next_cur.warm_start = BUS_WDATA;
          end
          OFS_WARM_LENGTH: begin
            next_cur.warm_len = BUS_WDATA;
          end
          OFS_WARM_EXEC: begin
            next_cur.warm_exec = BUS_WDATA;
          end
          OFS_WARM_CRC: begin
            next_cur.warm_crc = BUS_WDATA;
          end
          OFS_ADDR_REMAP: begin
            next_cur.remap = BUS_WDATA[0];
          end
          OFS_GLOBAL_FABRIC_DISABLE_REG: begin
            next_cur.global_disable = BUS_WDATA[0];
          end
          OFS_FABRIC_INDIV_EN: begin
            next_cur.indiv_en = BUS_WDATA[FABRIC_N-1:0];
          end
          OFS_ECC_MASK: begin
            next_cur.ecc_mask = BUS_WDATA[ECC_N-1:0];
          end
          OFS_L2_ERROR_INJECT_REG: begin
            next_cur.l2_inj = BUS_WDATA[1:0];
          end
          OFS_PARITY_INJECT: begin
            next_cur.parity_inj = BUS_WDATA[PARITY_N-1:0];
          end
          default: begin
            next_cur.ready = BUS_SEL;
          end
        endcase
      end
    end
    if (rd) begin
      if (BUS_ADDR[7:5] == HANDOFF_PAGE) begin
        next_cur.rdata = cur.handoff[BUS_ADDR[4:2]];
      end else begin
        case ({BUS_ADDR[7:2], 2'b00})
          OFS_USB_MASTER_ATTR_REG0: next_cur.rdata = 32'(cur.usb0_attr);
          OFS_USB_MASTER_ATTR_REG1: next_cur.rdata = 32'(cur.usb1_attr);
          OFS_CARD_MASTER_ATTR_REG: next_cur.rdata = 32'(cur.card_attr);
          OFS_CARD_CLK_PHASE: begin
            next_cur.rdata = 32'({1'b0, cur.smpl_sel, 1'b0, cur.drv_sel});
          end
          OFS_WD_DEBUG: next_cur.rdata = 32'(cur.wd_dbg);
          OFS_BOOT_CTRL: begin
            next_cur.rdata = 32'({cur.safe_update, cur.wait_state, cur.warm_io, cur.warm_pinmux});
          end
          OFS_LAST_IMAGE: next_cur.rdata = 32'(cur.last_image);
          OFS_BOOT_CODE_SCRATCH_STATE: next_cur.rdata = cur.sw_state;
          OFS_WARM_ENABLE: next_cur.rdata = 32'(cur.warm_en);
          OFS_WARM_START: next_cur.rdata = cur.warm_start;
          OFS_WARM_LENGTH: next_cur.rdata = cur.warm_len;
          OFS_WARM_EXEC: next_cur.rdata = cur.warm_exec;
          OFS_WARM_CRC: next_cur.rdata = cur.warm_crc;
          OFS_ADDR_REMAP: next_cur.rdata = 32'(cur.remap);
          OFS_GLOBAL_FABRIC_DISABLE_REG: next_cur.rdata = 32'(cur.global_disable);
          OFS_FABRIC_INDIV_EN: next_cur.rdata = 32'(cur.indiv_en);
          OFS_ECC_MASK: next_cur.rdata = 32'(cur.ecc_mask);
          OFS_L2_ERROR_INJECT_REG: next_cur.rdata = 32'(cur.l2_inj);
          OFS_PARITY_INJECT: next_cur.rdata = 32'(cur.parity_inj);
          default: next_cur.rdata = WORD_RST;
        endcase
      end
    end

    // Global disable overrides every individual enable in one step.
    next_cur.fabric_en = cur.global_disable ? '0 : cur.indiv_en;
    next_cur.ecc_irq = |(ECC_IRQ_SRC & ~cur.ecc_mask);
    // Parity injection only raises the interrupt; no data is touched.
    next_cur.parity_irq = cur.parity_inj;

    // Warm or cold reset clears the run-time controls and remap; on a warm reset the other boot, warm-boot and
    // handoff state survive (wait_state only while safe_update is clear) so boot code can read them afterwards.
    if (!warm_rst_n) begin
      next_cur.usb0_attr = ATTR_RST;
      next_cur.usb1_attr = ATTR_RST;
      next_cur.card_attr = ATTR_RST;
      next_cur.drv_sel = PHASE_RST;
      next_cur.smpl_sel = PHASE_RST;
      next_cur.wd_dbg = WD_DBG_RST;
      next_cur.remap = REMAP_RST;
      next_cur.global_disable = GLOBAL_DISABLE_RST;
      next_cur.indiv_en = INDIV_EN_RST;
      next_cur.ecc_mask = ECC_MASK_RST;
      next_cur.l2_inj = 2'h0;
      next_cur.parity_inj = '0;
      next_cur.rdata = WORD_RST;
      next_cur.ready = 1'b0;
      next_cur.fabric_en = '0;
      next_cur.ecc_irq = 1'b0;
      next_cur.parity_irq = '0;
      if (cur.safe_update) begin
        next_cur.wait_state = WAIT_STATE_RST;
      end
    end
    // Cold reset zeroes everything, the handoff array included, then loads the nonzero reset values.
    if (!COLD_RESET_N) begin
      next_cur = '0;
      next_cur.wd_dbg = WD_DBG_RST;
      next_cur.wait_state = WAIT_STATE_RST;
      next_cur.safe_update = SAFE_UPDATE_RST;
      next_cur.global_disable = GLOBAL_DISABLE_RST;
      next_cur.ecc_mask = ECC_MASK_RST;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    cur <= next_cur;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < WD_N; gi++) begin : g_pause
      scr_wd_pause u_pause (
        .clk(CLK_SYS),
        .rst_n(warm_rst_n),
        .debug_mode(CPU_DEBUG[gi]),
        .pause_en(cur.wd_dbg[gi]),
        .pause(WD_PAUSE[gi])
      );
    end
  endgenerate

  scr_l2_inject u_inject (
    .clk(CLK_SYS),
    .rst_n(warm_rst_n),
    .inj_single(cur.l2_inj[INJ_SINGLE_POS]),
    .inj_double(cur.l2_inj[INJ_DOUBLE_POS]),
    .mem_write(L2_WRITE),
    .corrupt_single(L2_CORRUPT_SINGLE),
    .corrupt_double(L2_CORRUPT_DOUBLE)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign BUS_RDATA = cur.rdata;
  assign BUS_READY = cur.ready;
  assign USB0_MASTER_PROT = cur.usb0_attr[PROT_W-1:0];
  assign USB0_MASTER_USER_SIDEBAND = cur.usb0_attr[ATTR_W-1:PROT_W];
  assign USB1_MASTER_PROT = cur.usb1_attr[PROT_W-1:0];
  assign USB1_MASTER_USER_SIDEBAND = cur.usb1_attr[ATTR_W-1:PROT_W];
  assign CARD_MASTER_PROT = cur.card_attr[PROT_W-1:0];
  assign CARD_MASTER_USER_SIDEBAND = cur.card_attr[ATTR_W-1:PROT_W];
  assign CARD_DRV_PHASE = cur.drv_sel;
  assign CARD_SMPL_PHASE = cur.smpl_sel;
  assign BOOT_WARM_PINMUX = cur.warm_pinmux;
  assign BOOT_WARM_IO = cur.warm_io;
  assign BOOTROM_WAIT_STATE = cur.wait_state;
  assign BOOT_MEM_REMAP = cur.remap;
  assign FABRIC_EN = cur.fabric_en;
  assign ECC_IRQ = cur.ecc_irq;
  assign PARITY_IRQ = cur.parity_irq;

endmodule

// ==== hw/scr_pkg.sv ====
// Constants shared by the system control register bank and its helpers.
// Assumes a single system clock and synchronous active-low resets.
package scr_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_USB_MASTER_ATTR_REG0 = 8'h00;
  localparam logic [7:0] OFS_USB_MASTER_ATTR_REG1 = 8'h04;
  localparam logic [7:0] OFS_CARD_MASTER_ATTR_REG = 8'h08;
  localparam logic [7:0] OFS_CARD_CLK_PHASE = 8'h0c;
  localparam logic [7:0] OFS_WD_DEBUG = 8'h10;
  localparam logic [7:0] OFS_BOOT_CTRL = 8'h14;
  localparam logic [7:0] OFS_LAST_IMAGE = 8'h18;
  localparam logic [7:0] OFS_BOOT_CODE_SCRATCH_STATE = 8'h1c;
  localparam logic [7:0] OFS_WARM_ENABLE = 8'h20;
  localparam logic [7:0] OFS_WARM_START = 8'h24;
  localparam logic [7:0] OFS_WARM_LENGTH = 8'h28;
  localparam logic [7:0] OFS_WARM_EXEC = 8'h2c;
  localparam logic [7:0] OFS_WARM_CRC = 8'h30;
  localparam logic [7:0] OFS_ADDR_REMAP = 8'h34;
  localparam logic [7:0] OFS_GLOBAL_FABRIC_DISABLE_REG = 8'h38;
  localparam logic [7:0] OFS_FABRIC_INDIV_EN = 8'h3c;
  localparam logic [7:0] OFS_ECC_MASK = 8'h40;
  localparam logic [7:0] OFS_L2_ERROR_INJECT_REG = 8'h44;
  localparam logic [7:0] OFS_PARITY_INJECT = 8'h48;
  // Handoff array occupies 0x60..0x7c, selected by address bits 7:5.
  localparam logic [2:0] HANDOFF_PAGE = 3'h3;

  // ----------------------------------------------------------------
  // Field widths and positions
  // ----------------------------------------------------------------
  localparam int PROT_W = 4;
  localparam int USER_W = 5;
  localparam int ATTR_W = PROT_W + USER_W;
  localparam int PHASE_W = 3;
  localparam int SMPL_POS = 4;
  localparam int WD_N = 2;
  localparam int IMAGE_W = 2;
  localparam int FABRIC_N = 14;
  localparam int ECC_N = 9;
  localparam int PARITY_N = 2;
  localparam int HANDOFF_N = 8;
  localparam int BOOT_PINMUX_POS = 0;
  localparam int BOOT_IO_POS = 1;
  localparam int BOOT_WAIT_POS = 2;
  localparam int BOOT_SAFE_POS = 3;
  localparam int INJ_SINGLE_POS = 0;
  localparam int INJ_DOUBLE_POS = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [ATTR_W-1:0] ATTR_RST = 9'h000;
  localparam logic [PHASE_W-1:0] PHASE_RST = 3'h0;
  localparam logic [WD_N-1:0] WD_DBG_RST = 2'h3;
  localparam logic WAIT_STATE_RST = 1'b0;
  localparam logic SAFE_UPDATE_RST = 1'b1;
  localparam logic REMAP_RST = 1'b0;
  localparam logic GLOBAL_DISABLE_RST = 1'b1;
  localparam logic [FABRIC_N-1:0] INDIV_EN_RST = 14'h0000;
  localparam logic [ECC_N-1:0] ECC_MASK_RST = 9'h1ff;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  // Least spacing, in system clock cycles, between two accepted injections.
  localparam int INJ_GAP_CYCLES = 5;
  localparam logic [2:0] INJ_GAP_RELOAD = 3'(INJ_GAP_CYCLES - 1);

endpackage

// ==== hw/scr_wd_pause.sv ====
// Pause driver for one watchdog timer.
// Assumes the debug-mode level comes from logic on the same clock.
module scr_wd_pause
  import scr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic debug_mode,
  input wire logic pause_en,
  // Pause output
  output logic pause
);

  typedef struct packed {
    logic pause;
  } scr_pause_t;

  scr_pause_t cur;
  scr_pause_t next_cur;

  always_comb begin
    next_cur = cur;
    next_cur.pause = debug_mode & pause_en;
    if (!rst_n) begin
      next_cur.pause = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    cur <= next_cur;
  end

  assign pause = cur.pause;

endmodule

// ==== hw/scr_l2_inject.sv ====
// Edge-sensitive L2 ECC error injection request handler.
// Assumes the control bits and the write strobe come from the same clock.
module scr_l2_inject
  import scr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control bits from the register bank
  input wire logic inj_single,
  input wire logic inj_double,
  // Memory write strobe
  input wire logic mem_write,
  // Armed corruption requests to the memory
  output logic corrupt_single,
  output logic corrupt_double
);

  typedef struct packed {
    logic prev_single;
    logic prev_double;
    logic req_single;
    logic req_double;
    logic arm_single;
    logic arm_double;
    logic [2:0] gap;
  } scr_inj_t;

  scr_inj_t cur;
  scr_inj_t next_cur;

  always_comb begin
    next_cur = cur;
    next_cur.prev_single = inj_single;
    next_cur.prev_double = inj_double;
    // An armed request is consumed by the next write.
    if (mem_write) begin
      next_cur.arm_single = 1'b0;
      next_cur.arm_double = 1'b0;
    end
    if (cur.gap != 3'h0) begin
      next_cur.gap = cur.gap - 3'h1;
    end
    // Captured requests wait here and cannot be withdrawn.
    if (cur.req_single && cur.gap == 3'h0 && !cur.arm_single) begin
      next_cur.req_single = 1'b0;
      next_cur.arm_single = 1'b1;
      next_cur.gap = INJ_GAP_RELOAD;
    end else if (cur.req_double && cur.gap == 3'h0 && !cur.arm_double) begin
      next_cur.req_double = 1'b0;
      next_cur.arm_double = 1'b1;
      next_cur.gap = INJ_GAP_RELOAD;
    end
    // A new rising edge is captured after the acceptance above.
    if (inj_single && !cur.prev_single) begin
      next_cur.req_single = 1'b1;
    end
    if (inj_double && !cur.prev_double) begin
      next_cur.req_double = 1'b1;
    end
    if (!rst_n) begin
      next_cur = '0;
    end
  end

  always_ff @(posedge clk) begin
    cur <= next_cur;
  end

  assign corrupt_single = cur.arm_single;
  assign corrupt_double = cur.arm_double;

endmodule

// ==== sim/scr_regs_assertions.sv ====
// Port-level checks for the system control register bank.
// Assumes one clock and that both resets gate every check.
module scr_regs_assertions
  import scr_pkg::*;
(
  // Clock and resets
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic COLD_RESET_N,
  // Register port
  input wire logic BUS_SEL,
  input wire logic BUS_WRITE,
  input wire logic [7:0] BUS_ADDR,
  input wire logic [31:0] BUS_WDATA,
  input wire logic [31:0] BUS_RDATA,
  input wire logic BUS_READY,
  // Side-band
  input wire logic [PROT_W-1:0] USB0_MASTER_PROT,
  input wire logic [USER_W-1:0] USB0_MASTER_USER_SIDEBAND,
  input wire logic [WD_N-1:0] CPU_DEBUG,
  input wire logic [WD_N-1:0] WD_PAUSE,
  input wire logic [FABRIC_N-1:0] FABRIC_EN,
  input wire logic [ECC_N-1:0] ECC_IRQ_SRC,
  input wire logic ECC_IRQ,
  input wire logic [PARITY_N-1:0] PARITY_IRQ,
  input wire logic L2_WRITE,
  input wire logic L2_CORRUPT_SINGLE,
  input wire logic L2_CORRUPT_DOUBLE
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N || !COLD_RESET_N);
  logic wr_usb0;
  logic wr_glb;
  logic wr_par;
  assign wr_usb0 = BUS_SEL && BUS_WRITE && BUS_ADDR[7:2] == OFS_USB_MASTER_ATTR_REG0[7:2];
  assign wr_glb = BUS_SEL && BUS_WRITE && BUS_ADDR[7:2] == OFS_GLOBAL_FABRIC_DISABLE_REG[7:2];
  assign wr_par = BUS_SEL && BUS_WRITE && BUS_ADDR[7:2] == OFS_PARITY_INJECT[7:2];

  AST_READY: assert property (BUS_SEL |=> BUS_READY)
    else $error("request not answered");
  AST_NO_READY: assert property (!BUS_SEL |=> !BUS_READY)
    else $error("answer without request");
  AST_RDATA_IDLE: assert property (!BUS_READY |-> BUS_RDATA == '0)
    else $error("read data outside answer");
  AST_ATTR: assert property (wr_usb0 |=>
    {USB0_MASTER_USER_SIDEBAND, USB0_MASTER_PROT} == ATTR_W'($past(BUS_WDATA)))
    else $error("master attribute not updated");
  AST_PAUSE: assert property (1'b1 |=> (WD_PAUSE & ~$past(CPU_DEBUG)) == '0)
    else $error("pause without debug");
  AST_FABRIC: assert property (wr_glb && BUS_WDATA[0] |-> ##2 FABRIC_EN == '0)
    else $error("fabric not cut off");
  AST_ECC: assert property (ECC_IRQ |-> $past(ECC_IRQ_SRC) != '0)
    else $error("ecc interrupt without source");
  AST_PARITY: assert property (wr_par |-> ##2 PARITY_IRQ == PARITY_N'($past(BUS_WDATA, 2)))
    else $error("parity interrupt wrong");
  AST_CORRUPT_FALL: assert property (L2_WRITE && L2_CORRUPT_SINGLE |=> !L2_CORRUPT_SINGLE)
    else $error("corruption not spent by write");
  AST_INJ_GAP: assert property ($rose(L2_CORRUPT_SINGLE) |=>
    (!$rose(L2_CORRUPT_SINGLE) && !$rose(L2_CORRUPT_DOUBLE)) [*4])
    else $error("injections too close");
endmodule

bind scr_regs scr_regs_assertions i_scr_regs_assertions (
  .CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .COLD_RESET_N(COLD_RESET_N), .BUS_SEL(BUS_SEL),
  .BUS_WRITE(BUS_WRITE), .BUS_ADDR(BUS_ADDR), .BUS_WDATA(BUS_WDATA), .BUS_RDATA(BUS_RDATA),
  .BUS_READY(BUS_READY), .USB0_MASTER_PROT(USB0_MASTER_PROT),
  .USB0_MASTER_USER_SIDEBAND(USB0_MASTER_USER_SIDEBAND), .CPU_DEBUG(CPU_DEBUG), .WD_PAUSE(WD_PAUSE),
  .FABRIC_EN(FABRIC_EN), .ECC_IRQ_SRC(ECC_IRQ_SRC), .ECC_IRQ(ECC_IRQ), .PARITY_IRQ(PARITY_IRQ),
  .L2_WRITE(L2_WRITE), .L2_CORRUPT_SINGLE(L2_CORRUPT_SINGLE), .L2_CORRUPT_DOUBLE(L2_CORRUPT_DOUBLE)
);

// ==== sim/scr_l2_mem_model.sv ====
// Behavioural L2 memory that writes on request and counts corrupted stores.
// Assumes requests come from the bench on the system clock.
module scr_l2_mem_model (
  // Clock
  input wire logic clk,
  // Requests
  input wire logic go,
  input wire logic [3:0] lag,
  // Memory side
  input wire logic corrupt_single,
  input wire logic corrupt_double,
  output logic mem_write,
  output int n_single,
  output int n_double
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_cnt = -1;
  initial begin
    mem_write = 1'b0;
    n_single = 0;
    n_double = 0;
  end
  always @(posedge clk) begin
    mem_write <= 1'b0;
    if (go) begin
      wait_cnt <= int'(lag);
    end else if (wait_cnt > 0) begin
      wait_cnt <= wait_cnt - 1;
    end else if (wait_cnt == 0) begin
      mem_write <= 1'b1;
      wait_cnt <= -1;
    end
    // A store made while an error is armed lands corrupted.
    if (mem_write && corrupt_single) n_single <= n_single + 1;
    if (mem_write && corrupt_double) n_double <= n_double + 1;
  end
endmodule

// ==== sim/tb_top.sv ====
// Self-checking bench for the system control register bank.
// Assumes a one-cycle register port and the L2 memory model beside it.
module tb_top
  import scr_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK_SYS = 1'b0;
  logic RESET_N = 1'b0;
  logic COLD_RESET_N = 1'b0;
  logic BUS_SEL = 1'b0;
  logic BUS_WRITE = 1'b0;
  logic [7:0] BUS_ADDR = 8'h00;
  logic [31:0] BUS_WDATA = 32'h0;
  logic [WD_N-1:0] CPU_DEBUG = 2'h0;
  logic [ECC_N-1:0] ECC_IRQ_SRC = 9'h000;
  logic go = 1'b0;
  logic [3:0] lag = 4'h0;
  logic [31:0] BUS_RDATA, q;
  logic BUS_READY, L2_WRITE, ECC_IRQ, L2_CORRUPT_SINGLE, L2_CORRUPT_DOUBLE;
  logic BOOT_WARM_PINMUX, BOOT_WARM_IO, BOOTROM_WAIT_STATE, BOOT_MEM_REMAP;
  logic [PROT_W-1:0] USB0_MASTER_PROT, USB1_MASTER_PROT, CARD_MASTER_PROT;
  logic [USER_W-1:0] USB0_MASTER_USER_SIDEBAND, USB1_MASTER_USER_SIDEBAND, CARD_MASTER_USER_SIDEBAND;
  logic [PHASE_W-1:0] CARD_DRV_PHASE, CARD_SMPL_PHASE;
  logic [WD_N-1:0] WD_PAUSE;
  logic [FABRIC_N-1:0] FABRIC_EN;
  logic [PARITY_N-1:0] PARITY_IRQ;
  int n_fail = 0;
  int tests_run = 0;
  int n_single, n_double;

  always #5 CLK_SYS = ~CLK_SYS;

  scr_regs i_scr_regs (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .COLD_RESET_N(COLD_RESET_N),
    .BUS_SEL(BUS_SEL), .BUS_WRITE(BUS_WRITE), .BUS_ADDR(BUS_ADDR), .BUS_WDATA(BUS_WDATA),
    .BUS_RDATA(BUS_RDATA), .BUS_READY(BUS_READY), .USB0_MASTER_PROT(USB0_MASTER_PROT),
    .USB0_MASTER_USER_SIDEBAND(USB0_MASTER_USER_SIDEBAND), .USB1_MASTER_PROT(USB1_MASTER_PROT),
    .USB1_MASTER_USER_SIDEBAND(USB1_MASTER_USER_SIDEBAND), .CARD_MASTER_PROT(CARD_MASTER_PROT),
    .CARD_MASTER_USER_SIDEBAND(CARD_MASTER_USER_SIDEBAND), .CARD_DRV_PHASE(CARD_DRV_PHASE),
    .CARD_SMPL_PHASE(CARD_SMPL_PHASE), .CPU_DEBUG(CPU_DEBUG), .WD_PAUSE(WD_PAUSE),
    .BOOT_WARM_PINMUX(BOOT_WARM_PINMUX), .BOOT_WARM_IO(BOOT_WARM_IO), .BOOTROM_WAIT_STATE(BOOTROM_WAIT_STATE),
    .BOOT_MEM_REMAP(BOOT_MEM_REMAP), .FABRIC_EN(FABRIC_EN), .ECC_IRQ_SRC(ECC_IRQ_SRC), .ECC_IRQ(ECC_IRQ),
    .PARITY_IRQ(PARITY_IRQ), .L2_WRITE(L2_WRITE), .L2_CORRUPT_SINGLE(L2_CORRUPT_SINGLE),
    .L2_CORRUPT_DOUBLE(L2_CORRUPT_DOUBLE));
  scr_l2_mem_model i_scr_l2_mem_model (.clk(CLK_SYS), .go(go), .lag(lag), .corrupt_single(L2_CORRUPT_SINGLE),
    .corrupt_double(L2_CORRUPT_DOUBLE), .mem_write(L2_WRITE), .n_single(n_single), .n_double(n_double));

  task automatic tick(input int n);
    repeat (n) @(posedge CLK_SYS);
    #1;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One request; the idle cycle after it keeps the select from toggling twice in one step.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    BUS_SEL = 1'b1;
    BUS_WRITE = w;
    BUS_ADDR = a;
    BUS_WDATA = d;
    tick(1);
    BUS_SEL = 1'b0;
    q = BUS_RDATA;
    chk("ready", 32'h1, 32'(BUS_READY));
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    chk(what, exp, q);
  endtask
  task automatic rst(input logic cold);
    RESET_N = 1'b0;
    COLD_RESET_N = !cold;
    tick(2);
    RESET_N = 1'b1;
    COLD_RESET_N = 1'b1;
  endtask

  task automatic t_reset_values();
    rd(8'h10, 32'h3, "wd debug");
    rd(8'h14, 32'h8, "boot ctrl");
    rd(8'h38, 32'h1, "global disable");
    rd(8'h40, 32'h1ff, "ecc mask");
    rd(8'h60, 32'h0, "handoff");
    chk("fabric", 32'h0, 32'(FABRIC_EN));
  endtask
  task automatic t_readback();
    logic [7:0] ofs [18] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20,
      8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h3c, 8'h40, 8'h60, 8'h7c};
    logic [31:0] val [18] = '{32'h1ff, 32'h1ff, 32'h1ff, 32'h77, 32'h3, 32'hf, 32'h3, 32'hffffffff, 32'h1,
      32'hfffffffc, 32'hffffffff, 32'hffffffff, 32'hffffffff, 32'h1, 32'h3fff, 32'h1ff, 32'h1, 32'h2};
    for (int i = 0; i < 18; i++) begin
      bus(1'b1, ofs[i], val[i]);
      rd(ofs[i], val[i], "readback");
    end
    chk("usb0", 32'h1ff, 32'({USB0_MASTER_USER_SIDEBAND, USB0_MASTER_PROT}));
    chk("usb1", 32'h1ff, 32'({USB1_MASTER_USER_SIDEBAND, USB1_MASTER_PROT}));
    chk("card", 32'h1ff, 32'({CARD_MASTER_USER_SIDEBAND, CARD_MASTER_PROT}));
    chk("phase", 32'h77, 32'({1'b0, CARD_SMPL_PHASE, 1'b0, CARD_DRV_PHASE}));
    chk("boot", 32'hf, 32'({BOOT_MEM_REMAP, BOOTROM_WAIT_STATE, BOOT_WARM_IO, BOOT_WARM_PINMUX}));
    bus(1'b1, 8'h50, 32'hffffffff);
    rd(8'h50, 32'h0, "unmapped");
  endtask
  task automatic t_resets();
    bus(1'b1, 8'h14, 32'h4);
    rst(1'b0);
    chk("wait kept", 32'h1, 32'(BOOTROM_WAIT_STATE));
    chk("usb0 warm", 32'h0, 32'(USB0_MASTER_PROT));
    rd(8'h7c, 32'h2, "handoff warm");
    rd(8'h1c, 32'hffffffff, "scratch warm");
    rd(8'h24, 32'hfffffffc, "warm start kept");
    bus(1'b1, 8'h14, 32'hc);
    rst(1'b0);
    chk("wait cleared", 32'h0, 32'(BOOTROM_WAIT_STATE));
    rst(1'b1);
    rd(8'h7c, 32'h0, "handoff cold");
    rd(8'h1c, 32'h0, "scratch cold");
  endtask
  task automatic t_sideband();
    bus(1'b1, 8'h3c, 32'h3fff);
    bus(1'b1, 8'h38, 32'h0);
    chk("fabric on", 32'h3fff, 32'(FABRIC_EN));
    bus(1'b1, 8'h3c, 32'h2a5);
    chk("fabric some", 32'h2a5, 32'(FABRIC_EN));
    bus(1'b1, 8'h38, 32'h1);
    chk("fabric off", 32'h0, 32'(FABRIC_EN));
    bus(1'b1, 8'h10, 32'h1);
    CPU_DEBUG = 2'h3;
    tick(1);
    chk("pause", 32'h1, 32'(WD_PAUSE));
    bus(1'b1, 8'h10, 32'h2);
    chk("pause", 32'h2, 32'(WD_PAUSE));
    CPU_DEBUG = 2'h1;
    tick(1);
    chk("pause", 32'h0, 32'(WD_PAUSE));
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, 8'h48, 32'(i + 1));
      chk("parity", 32'(i + 1), 32'(PARITY_IRQ));
    end
  endtask
  task automatic t_ecc();
    for (int i = 0; i < ECC_N; i++) begin
      bus(1'b1, 8'h40, 32'(~(9'h001 << i)));
      ECC_IRQ_SRC = 9'h001 << i;
      tick(1);
      chk("ecc open", 32'h1, 32'(ECC_IRQ));
      ECC_IRQ_SRC = ~(9'h001 << i);
      tick(1);
      chk("ecc masked", 32'h0, 32'(ECC_IRQ));
    end
  endtask
  task automatic t_inject();
    bus(1'b1, 8'h44, 32'h1);
    bus(1'b1, 8'h44, 32'h3);
    chk("single armed", 32'h1, 32'(L2_CORRUPT_SINGLE));
    chk("double held", 32'h0, 32'(L2_CORRUPT_DOUBLE));
    go = 1'b1;
    tick(1);
    go = 1'b0;
    bus(1'b1, 8'h44, 32'h0);
    tick(4);
    chk("single stores", 32'h1, 32'(n_single));
    chk("single spent", 32'h0, 32'(L2_CORRUPT_SINGLE));
    chk("double armed", 32'h1, 32'(L2_CORRUPT_DOUBLE));
    lag = 4'h3;
    go = 1'b1;
    tick(1);
    go = 1'b0;
    tick(6);
    chk("double stores", 32'h1, 32'(n_double));
    chk("double spent", 32'h0, 32'(L2_CORRUPT_DOUBLE));
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge CLK_SYS);
    n_fail++;
    test_done();
  end
  initial begin
    tick(20);
    RESET_N = 1'b1;
    COLD_RESET_N = 1'b1;
    t_reset_values();
    t_readback();
    t_resets();
    t_sideband();
    t_ecc();
    t_inject();
    test_done();
  end
endmodule
